/* rtl/odg_pkg.sv */
// Shared constants for the output driver enable gate
package odg_pkg;
   localparam int              ODG_ADDR_W      = 10;
   localparam int              ODG_DATA_W      = 16;
   localparam int              ODG_STAT_W      = 7;
   localparam int              ODG_SYNC_STAGES = 2;
   localparam logic [9:0]      ODG_STATUS_ADDR = 10'h1D2;
   // Status field positions
   localparam int              ODG_B_CORE      = 0;
   localparam int              ODG_B_FIVE      = 1;
   localparam int              ODG_B_BOOST     = 2;
   localparam int              ODG_B_TEMP      = 3;
   localparam int              ODG_B_PIN_LIVE  = 4;
   localparam int              ODG_B_PIN_LATCH = 5;
   localparam int              ODG_B_CLKMISS   = 6;
   // Status reset value: only the pin latch starts at one
   localparam logic [6:0]      ODG_STAT_RESET  = 7'h20;
   // Synchronised input vector layout
   localparam int              ODG_IN_W        = 6;
   localparam int              ODG_I_PIN       = 0;
   localparam int              ODG_I_CORE      = 1;
   localparam int              ODG_I_FIVE      = 2;
   localparam int              ODG_I_BOOST     = 3;
   localparam int              ODG_I_TEMP      = 4;
   localparam int              ODG_I_GND       = 5;
endpackage : odg_pkg

/* rtl/odg_sync_if.sv */
// Carrier between the gate and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface odg_sync_if #(parameter int W = 6);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport owner (output raw, input synced);
   modport sync  (input raw, output synced);
endinterface : odg_sync_if
`default_nettype wire

/* rtl/odg_sync.sv */
// Multi-bit two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module odg_sync
   import odg_pkg::*;
#(
   parameter int W = ODG_IN_W
) (
   input  wire logic ref_clk,
   input  wire logic rstn,
   odg_sync_if.sync  port
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;

   initial begin
      if (W < 1) $error("odg_sync: width must be at least one");
   end

   // First stage is read only by the second
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= port.raw;
         stage2 <= stage1;
      end
   end

   assign port.synced = stage2;
endmodule : odg_sync
`default_nettype wire

/* rtl/odg_gate.sv */
// Driver enable gating and sticky driver fault status
`timescale 1ns/1ps
`default_nettype none
// Function
// - Separate enables for high-side group and low-side group.
// - Low-side one to six need clock ok, pin high, no supply lows.
// - Low-side seven as one to six, pin dependence configurable.
// - High-side needs clock ok, pin, no supply lows, optional boost.
// - Clock ok term gated by option, else stays one.
// - Seven-bit status latches every driver-disabling error.
// - Bit 6 set on clock missing disable, resets to zero.
// - Bit 5 resets to one, clears when pin was low since clear.
// - Bit 4 is live pin level, never latched.
// - Bit 3 latches overtemperature, never disables drivers.
// - Bit 2 set when boost low disables high-side, if configured.
// - Bit 1 latches five volt supply low.
// - Bit 0 latches core supply low or ground loss.
// - Error bits clear on status write only once cause is gone.
// - With clear-on-read, status read also clears gone errors.
// - Override set makes low-side seven ignore the pin.
// - Boost low disables high-side only with boost option set.
// - With clock option set, clock ok is zero while clock missing.
module odg_gate
   import odg_pkg::*;
#(
   parameter int ADDR_W = ODG_ADDR_W,
   parameter int DATA_W = ODG_DATA_W
) (
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              drive_enable_pin,
   input  wire logic              core_supply_low_flag,
   input  wire logic              five_volt_low_flag,
   input  wire logic              boost_low_flag,
   input  wire logic              over_temp_flag,
   input  wire logic              ground_loss_flag,
   input  wire logic              clock_missing,
   input  wire logic              clock_missing_disable,
   input  wire logic              boost_disable,
   input  wire logic              low_seven_override,
   input  wire logic              clear_on_read,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   output logic                   high_side_enable,
   output logic                   low_side_enable,
   output logic                   low_seven_enable
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   initial begin
      if (ADDR_W < $bits(ODG_STATUS_ADDR)) $error("odg_gate: address too narrow");
      if (ODG_SYNC_STAGES < 1) $error("odg_gate: sync needs at least one stage");
      if (DATA_W < ODG_STAT_W) $error("odg_gate: data narrower than status");
   end

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   // Analog flags are asynchronous too, so they share the pin's path
   odg_sync_if #(.W(ODG_IN_W)) sync_bus ();

   logic [ODG_IN_W-1:0] raw_in;

   // One driver for the whole carrier word, bits placed by name
   always_comb begin
      raw_in              = '0;
      raw_in[ODG_I_PIN]   = drive_enable_pin;
      raw_in[ODG_I_CORE]  = core_supply_low_flag;
      raw_in[ODG_I_FIVE]  = five_volt_low_flag;
      raw_in[ODG_I_BOOST] = boost_low_flag;
      raw_in[ODG_I_TEMP]  = over_temp_flag;
      raw_in[ODG_I_GND]   = ground_loss_flag;
   end

   assign sync_bus.raw = raw_in;

   odg_sync #(.W(ODG_IN_W)) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .port    (sync_bus.sync)
   );

   logic pin_s;
   logic core_low_s;
   logic five_low_s;
   logic boost_low_s;
   logic temp_s;
   logic gnd_s;

   assign pin_s       = sync_bus.synced[ODG_I_PIN];
   assign core_low_s  = sync_bus.synced[ODG_I_CORE];
   assign five_low_s  = sync_bus.synced[ODG_I_FIVE];
   assign boost_low_s = sync_bus.synced[ODG_I_BOOST];
   assign temp_s      = sync_bus.synced[ODG_I_TEMP];
   assign gnd_s       = sync_bus.synced[ODG_I_GND];

   // ------------------------------------------------------------
   // Synchroniser fill
   // ------------------------------------------------------------
   // Reset zeros in the pin path look like a low pin; the pin latch
   // waits until real samples have reached the synchroniser output
   localparam int FILL_W = $clog2(ODG_SYNC_STAGES + 1);

   logic [FILL_W-1:0] fill;
   logic [FILL_W-1:0] next_fill;
   logic              fill_done;

   assign fill_done = (fill == FILL_W'(ODG_SYNC_STAGES));

   always_comb begin
      next_fill = fill;
      if (!fill_done) begin
         next_fill = fill + FILL_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fill <= '0;
      end else begin
         fill <= next_fill;
      end
   end

   // ------------------------------------------------------------
   // Enable terms
   // ------------------------------------------------------------
   logic clock_ok;
   logic supply_ok;
   logic boost_trip;
   logic clk_trip;

   // Clock missing is on our clock already, no synchroniser
   assign clk_trip   = clock_missing_disable & clock_missing;
   assign clock_ok   = ~clk_trip;
   assign supply_ok  = ~core_low_s & ~five_low_s & ~gnd_s;
   assign boost_trip = boost_disable & boost_low_s;

   logic next_hs;
   logic next_ls;
   logic next_ls7;

   always_comb begin
      // Overtemperature deliberately absent from every term
      next_ls  = clock_ok & pin_s & supply_ok;
      next_ls7 = clock_ok & (pin_s | low_seven_override) & supply_ok;
      next_hs  = clock_ok & pin_s & supply_ok & ~boost_trip;
   end

   // Registered so a flag glitch never reaches a predriver directly
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         high_side_enable <= 1'b0;
         low_side_enable  <= 1'b0;
         low_seven_enable <= 1'b0;
      end else begin
         high_side_enable <= next_hs;
         low_side_enable  <= next_ls;
         low_seven_enable <= next_ls7;
      end
   end

   // ------------------------------------------------------------
   // Driver fault status
   // ------------------------------------------------------------
   logic [ODG_STAT_W-1:0] status;
   logic [ODG_STAT_W-1:0] next_status;
   logic [DATA_W-1:0]     next_rdata;
   logic                  hit;
   logic                  clr;

   assign hit = (reg_addr == ADDR_W'(ODG_STATUS_ADDR));
   // Any write to the status address clears; write data carries no meaning here
   assign clr = hit & (reg_wr | (reg_rd & clear_on_read));

   always_comb begin
      next_status = status;
      // Cause present wins over a clear in the same cycle
      next_status[ODG_B_CLKMISS] = clk_trip |
         (status[ODG_B_CLKMISS] & ~clr);
      if (fill_done) begin
         next_status[ODG_B_PIN_LATCH] = pin_s &
            (status[ODG_B_PIN_LATCH] | clr);
      end
      next_status[ODG_B_PIN_LIVE] = pin_s;
      next_status[ODG_B_TEMP] = temp_s |
         (status[ODG_B_TEMP] & ~clr);
      next_status[ODG_B_BOOST] = boost_trip |
         (status[ODG_B_BOOST] & ~clr);
      next_status[ODG_B_FIVE] = five_low_s |
         (status[ODG_B_FIVE] & ~clr);
      next_status[ODG_B_CORE] = core_low_s | gnd_s |
         (status[ODG_B_CORE] & ~clr);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status <= ODG_STAT_RESET;
      end else begin
         status <= next_status;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Registered, so the host samples a settled word a cycle later
   always_comb begin
      // Read returns the value held before this access clears it
      next_rdata = '0;
      if (reg_rd && hit) begin
         next_rdata = DATA_W'(status);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule : odg_gate
`default_nettype wire

/* rtl/odg_keep.sv */
// Empty compilation unit, holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* test/odg_gate_properties.sv */
// Port checker for the driver enable gate
`timescale 1ns/1ps
`default_nettype none
module odg_gate_properties
   import odg_pkg::*;
#(
   parameter int ADDR_W = ODG_ADDR_W,
   parameter int DATA_W = ODG_DATA_W
) (
   input wire logic              ref_clk,
   input wire logic              rstn,
   input wire logic              five_volt_low_flag,
   input wire logic              boost_low_flag,
   input wire logic              clock_missing,
   input wire logic              clock_missing_disable,
   input wire logic              boost_disable,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              high_side_enable,
   input wire logic              low_side_enable,
   input wire logic              low_seven_enable
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // Four edges cover two sync stages plus the output register
   sequence s_five;
      five_volt_low_flag [*4];
   endsequence
   sequence s_boost;
      (boost_low_flag && boost_disable) [*4];
   endsequence
   property p_cm;
      clock_missing && clock_missing_disable |=>
         !(high_side_enable || low_side_enable || low_seven_enable);
   endproperty
   a_cm: assert property (p_cm) else $error("enable with clock missing");
   property p_five;
      s_five |-> !(high_side_enable || low_side_enable || low_seven_enable);
   endproperty
   a_five: assert property (p_five) else $error("enable on five low");
   property p_boost;
      s_boost |-> !high_side_enable;
   endproperty
   a_boost: assert property (p_boost) else $error("high on boost low");
   property p_ls7;
      low_side_enable |-> low_seven_enable;
   endproperty
   a_ls7: assert property (p_ls7) else $error("seven off, low on");
   property p_hs;
      high_side_enable |-> low_side_enable;
   endproperty
   a_hs: assert property (p_hs) else $error("high on, low off");
   property p_idle;
      !reg_rd |=> reg_rdata == '0;
   endproperty
   a_idle: assert property (p_idle) else $error("data without read");
   property p_miss;
      reg_rd && reg_addr != ODG_STATUS_ADDR |=> reg_rdata == '0;
   endproperty
   a_miss: assert property (p_miss) else $error("data on miss");
   property p_top;
      reg_rd |=> reg_rdata[DATA_W-1:ODG_STAT_W] == '0;
   endproperty
   a_top: assert property (p_top) else $error("upper bits set");
endmodule : odg_gate_properties
bind odg_gate odg_gate_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

/* test/odg_host.sv */
// Host model issuing status accesses
`timescale 1ns/1ps
`default_nettype none
module odg_host
   import odg_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic [ODG_DATA_W-1:0] reg_rdata,
   output logic      [ODG_ADDR_W-1:0] reg_addr,
   output logic                       reg_wr,
   output logic                       reg_rd
);
   // ----
   // Bus tasks
   // ----
   initial begin
      reg_addr = ~ODG_STATUS_ADDR;
      reg_wr   = 1'b0;
      reg_rd   = 1'b0;
   end
   // Address flips when idle so a stale value is never trusted
   task automatic wr(input logic [ODG_ADDR_W-1:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wr   = 1'b1;
      @(negedge ref_clk);
      reg_wr   = 1'b0;
      reg_addr = ~a;
   endtask : wr
   task automatic rd(input logic [ODG_ADDR_W-1:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask : rd
endmodule : odg_host
`default_nettype wire

/* test/output_driver_enable_gate_tb.sv */
// Self-checking bench for the driver enable gate
`timescale 1ns/1ps
`default_nettype none
module output_driver_enable_gate_tb;
   import odg_pkg::*;
   logic ref_clk = 1'b0, rstn = 1'b0, drive_enable_pin = 1'b0;
   logic clock_missing_disable = 1'b0, boost_disable = 1'b0;
   logic low_seven_override = 1'b0, clear_on_read = 1'b0;
   logic [5:0] flt = 6'h00;
   logic [ODG_ADDR_W-1:0] reg_addr;
   logic reg_wr, reg_rd, high_side_enable, low_side_enable, low_seven_enable;
   logic [15:0] reg_rdata, d;
   int n_errors = 0, checks = 0;
   // Fault, options, status bits, enables
   logic [17:0] cs [8] = '{{6'h01,2'h3,7'h01,3'h0}, {6'h02,2'h3,7'h02,3'h0},
      {6'h04,2'h1,7'h04,3'h3}, {6'h04,2'h0,7'h00,3'h7},
      {6'h08,2'h0,7'h08,3'h7}, {6'h10,2'h0,7'h01,3'h0},
      {6'h20,2'h2,7'h40,3'h0}, {6'h20,2'h0,7'h00,3'h7}};
   always #12.5 ref_clk = ~ref_clk;
   odg_gate dut (.ref_clk, .rstn, .drive_enable_pin,
      .core_supply_low_flag(flt[0]), .five_volt_low_flag(flt[1]),
      .boost_low_flag(flt[2]), .over_temp_flag(flt[3]),
      .ground_loss_flag(flt[4]), .clock_missing(flt[5]),
      .clock_missing_disable, .boost_disable, .low_seven_override,
      .clear_on_read, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
      .high_side_enable, .low_side_enable, .low_seven_enable);
   odg_host host (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd);
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic rdc(input logic [15:0] e);
      logic [15:0] v;
      host.rd(ODG_STATUS_ADDR, v);
      chk(v, e);
   endtask : rdc
   task automatic en(input logic [2:0] e);
      chk({13'h0, high_side_enable, low_side_enable, low_seven_enable},
         {13'h0, e});
   endtask : en
   task automatic w6;
      repeat (6) @(negedge ref_clk);
   endtask : w6
   task automatic final_report;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   // ----
   // Sequence
   // ----
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      rstn = 1'b1;
      w6();
      rdc(16'h0000);
      drive_enable_pin = 1'b1;
      w6();
      host.wr(ODG_STATUS_ADDR);
      rdc(16'h0030);
      for (int i = 0; i < 8; i++) begin
         {flt, clock_missing_disable, boost_disable} = cs[i][17:10];
         w6();
         en(cs[i][2:0]);
         flt = 6'h00;
         w6();
         rdc(16'h0030 | {9'h0, cs[i][9:3]});
         rdc(16'h0030 | {9'h0, cs[i][9:3]});
         host.wr(ODG_STATUS_ADDR);
         rdc(16'h0030);
      end
      flt = 6'h01;
      w6();
      host.wr(ODG_STATUS_ADDR);
      rdc(16'h0031);
      flt = 6'h02;
      w6();
      flt = 6'h00;
      w6();
      clear_on_read = 1'b1;
      rdc(16'h0033);
      rdc(16'h0030);
      clear_on_read = 1'b0;
      drive_enable_pin = 1'b0;
      low_seven_override = 1'b1;
      w6();
      en(3'h1);
      low_seven_override = 1'b0;
      w6();
      en(3'h0);
      rdc(16'h0000);
      drive_enable_pin = 1'b1;
      w6();
      host.rd(10'h1D3, d);
      chk(d, 16'h0000);
      rstn = 1'b0;
      repeat (2) @(negedge ref_clk);
      rstn = 1'b1;
      w6();
      en(3'h7);
      rdc(16'h0030);
      final_report();
   end
endmodule : output_driver_enable_gate_tb
`default_nettype wire
